// >>> rtl/fbds_defines.svh
`ifndef FBDS_DEFINES_SVH
`define FBDS_DEFINES_SVH

// Widths of current and time fields.
`define FBDS_CUR_W          16
`define FBDS_TIME_W         20
// Encodings.
`define FBDS_BRAKE_IMM_ON   1'h1
`define FBDS_WARN_OFF       16'h0000
`define FBDS_DISMODE_CS_BRK 2'h2
`define FBDS_DISMODE_CS_DB  2'h3
`define FBDS_DIN_CS_MODE    4'hD
// Hardware-enable delay cap, in ms, and its length in core_clk cycles (longest time, rounds down).
`define FBDS_HWEN_MAX_MS    167
`define FBDS_CLK_HZ         100000000
`define FBDS_HWEN_MAX_CYC   ((`FBDS_HWEN_MAX_MS * (`FBDS_CLK_HZ / 1000)))
// Control-cycle tick divider: one tick every this many core_clk cycles.
`define FBDS_TICK_DIV       100
// Fold step shift: a larger time-constant code means a slower exponential.
`define FBDS_FOLD_SHIFT_W   4

`endif

// >>> rtl/fbds_pkg.sv
package fbds_pkg;
    typedef enum logic [2:0] {
        FBDS_IDLE,
        FBDS_RELEASE_WAIT,
        FBDS_ACTIVE,
        FBDS_STOPPING,
        FBDS_APPLY_WAIT,
        FBDS_HW_HOLD
    } fbds_state_t;
endpackage

// >>> rtl/fbds_seq.sv
`timescale 1ns/1ps
`include "fbds_defines.svh"

// Operation
// - A warning is raised while the motor or overall limit is below a nonzero warning threshold.
// - A fault is raised and the power stage is removed while either limit is below the fault threshold.
// - A zero warning threshold turns warnings off; software keeps it between fault level and limits.
// - A user fault threshold above the default is ignored, a lower one becomes the effective one.
// - The overall limit is the instantaneous minimum of the drive and motor foldback limits.
// - After the peak hold time expires under peak demand the motor limit decays exponentially.
// - While demand stays below continuous rating the motor limit recovers toward full capacity.
// - With a brake fitted it is released only after the drive has been active for the release delay.
// - On a delayed disable the brake is applied and the drive held active for the apply delay.
// - When the immediate-brake setting is one the brake is applied at once on any disable.
// - A controlled stop from an input or a software disable applies the brake when the stop completes.
// - Brake delays apply only to controlled-stop and software disables; others cut power at once, except hardware enable removal with nonzero delay.
//   The code ignores hardware enable removal during a running apply delay and keeps power until that delay ends.
// - Hardware enable removal with nonzero delay applies the brake and holds power for the capped delay; during a controlled stop the code cuts power at once.
// - A hardware-enable delay of zero turns the delayed disable off and zero is the default.
// - Disable modes 2 and 3 stop first, falling back to brake or dynamic braking if stop is impossible.
// - Hardware enable, software enable, safe torque off, fault or a stop input are disable sources.
module fbds_seq #(
    parameter int CUR_W  = `FBDS_CUR_W,
    parameter int TIME_W = `FBDS_TIME_W,
    parameter int HWEN_MAX_CYC = `FBDS_HWEN_MAX_CYC
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic [CUR_W-1:0]  drive_fold_limit,
    input  wire logic [CUR_W-1:0]  current_demand,
    input  wire logic [CUR_W-1:0]  motor_peak_current,
    input  wire logic [CUR_W-1:0]  motor_cont_current,
    input  wire logic [TIME_W-1:0] motor_peak_hold_time,
    input  wire logic [3:0]        motor_fold_time_constant,
    input  wire logic [3:0]        motor_fold_recovery_time,
    input  wire logic [CUR_W-1:0]  warn_threshold,
    input  wire logic [CUR_W-1:0]  default_fault_threshold,
    input  wire logic [CUR_W-1:0]  user_fault_threshold,
    input  wire logic              fault_reset,
    input  wire logic              brake_fitted,
    input  wire logic [TIME_W-1:0] brake_release_delay,
    input  wire logic [TIME_W-1:0] brake_apply_delay,
    input  wire logic              brake_immediate_on_disable,
    input  wire logic [TIME_W-1:0] hw_enable_disable_delay,
    input  wire logic [1:0]        disable_action_select,
    input  wire logic [3:0]        input_function_select,
    input  wire logic              hw_enable_pin,
    input  wire logic              sw_enable,
    input  wire logic              sto_active_pin,
    input  wire logic              stop_input_pin,
    input  wire logic              stop_complete,
    input  wire logic              stop_impossible,
    output logic                   power_stage_on,
    output logic                   brake_release,
    output logic                   dynamic_brake,
    output logic                   stop_request,
    output logic                   fold_warning,
    output logic                   fold_fault,
    output logic [CUR_W-1:0]       motor_fold_limit,
    output logic [CUR_W-1:0]       overall_fold_limit
);
    if (CUR_W < 4 || TIME_W < 2 || TIME_W > 32 || HWEN_MAX_CYC < 1) begin : g_bad_params
        $error("fbds_seq: parameter values out of range.");
    end

    // Pin synchronisers: the first stage is read only by the second.
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic       hw_en_s;
    logic       sto_s;
    logic       stop_in_s;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
        end else begin
            pin_s1_q <= {stop_input_pin, sto_active_pin, hw_enable_pin};
            pin_s2_q <= pin_s1_q;
        end
    end
    assign hw_en_s   = pin_s2_q[0];
    assign sto_s     = pin_s2_q[1];
    assign stop_in_s = pin_s2_q[2];

    // Control-cycle tick.
    logic [7:0] tick_cnt_q;
    logic [7:0] tick_cnt_d;
    logic       tick;

    always_comb begin
        tick       = (tick_cnt_q == 8'(`FBDS_TICK_DIV - 1));
        tick_cnt_d = tick ? 8'h00 : tick_cnt_q + 8'h01;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tick_cnt_q <= 8'h00;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // Motor foldback: hold at peak, then decay, recover below continuous.
    logic [CUR_W-1:0]  mlim_q;
    logic [CUR_W-1:0]  mlim_d;
    logic [TIME_W-1:0] hold_q;
    logic [TIME_W-1:0] hold_d;
    logic [CUR_W-1:0]  olim_q;
    logic [CUR_W-1:0]  olim_d;
    logic [CUR_W-1:0]  eff_fault;
    logic [CUR_W-1:0]  fold_step;
    logic              warn_d;
    logic              flt_q;
    logic              flt_d;
    logic              warn_q;

    always_comb begin
        mlim_d = mlim_q;
        hold_d = hold_q;
        fold_step = '0;
        if (tick) begin
            if (current_demand > motor_cont_current) begin
                if (hold_q < motor_peak_hold_time) begin
                    hold_d = hold_q + 1'b1;
                end else if (mlim_q > motor_cont_current) begin
                    // Exponential step toward continuous current.
                    fold_step = (mlim_q - motor_cont_current) >> motor_fold_time_constant;
                    mlim_d = mlim_q - ((fold_step == '0) ? CUR_W'(1) : fold_step);
                end
            end else begin
                if (hold_q != '0) begin
                    hold_d = hold_q - 1'b1;
                end
                // Recovery speed does not depend on demand; the step is the gap to peak current shifted right by the recovery-time code.
                if (mlim_q < motor_peak_current) begin
                    // A step never passes the target, so the limit cannot wrap at full scale.
                    fold_step = (motor_peak_current - mlim_q) >> motor_fold_recovery_time;
                    mlim_d = mlim_q + ((fold_step == '0) ? CUR_W'(1) : fold_step);
                end
            end
            if (mlim_d > motor_peak_current) begin
                mlim_d = motor_peak_current;
            end
        end
        olim_d = (drive_fold_limit < mlim_d) ? drive_fold_limit : mlim_d;
        eff_fault = (user_fault_threshold < default_fault_threshold) ?
            user_fault_threshold : default_fault_threshold;
        warn_d = (warn_threshold != `FBDS_WARN_OFF) &&
            ((mlim_d < warn_threshold) || (olim_d < warn_threshold));
        flt_d = flt_q;
        if ((mlim_d < eff_fault) || (olim_d < eff_fault)) begin
            flt_d = 1'b1;
        end else if (fault_reset) begin
            flt_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mlim_q <= '1;
            hold_q <= '0;
            olim_q <= '1;
            warn_q <= 1'b0;
            flt_q  <= 1'b0;
        end else begin
            mlim_q <= mlim_d;
            hold_q <= hold_d;
            olim_q <= olim_d;
            warn_q <= warn_d;
            flt_q  <= flt_d;
        end
    end

    // Enable and brake sequencer.
    fbds_pkg::fbds_state_t st_q;
    fbds_pkg::fbds_state_t st_d;
    logic [TIME_W-1:0] tmr_q;
    logic [TIME_W-1:0] tmr_d;
    logic [TIME_W-1:0] hw_hold;
    logic              pwr_q;
    logic              pwr_d;
    logic              brk_rel_q;
    logic              brk_rel_d;
    logic              db_q;
    logic              db_d;
    logic              stop_q;
    logic              stop_d;
    logic              cs_input;
    logic              cs_mode;
    logic              hard_off;

    always_comb begin
        cs_input = stop_in_s && (input_function_select == `FBDS_DIN_CS_MODE);
        cs_mode  = (disable_action_select == `FBDS_DISMODE_CS_BRK) ||
            (disable_action_select == `FBDS_DISMODE_CS_DB);
        hard_off = flt_d || sto_s;
        // The cap is compared at full width, so a cap beyond the field's range never truncates.
        hw_hold  = (32'(hw_enable_disable_delay) > 32'(HWEN_MAX_CYC)) ?
            TIME_W'(HWEN_MAX_CYC) : hw_enable_disable_delay;
        st_d      = st_q;
        tmr_d     = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
        pwr_d     = pwr_q;
        brk_rel_d = brk_rel_q;
        db_d      = 1'b0;
        stop_d    = 1'b0;
        case (st_q)
            fbds_pkg::FBDS_IDLE: begin
                pwr_d     = 1'b0;
                brk_rel_d = 1'b0;
                if (hw_en_s && sw_enable && !hard_off && !cs_input) begin
                    st_d  = fbds_pkg::FBDS_RELEASE_WAIT;
                    pwr_d = 1'b1;
                    tmr_d = brake_release_delay;
                end
            end
            fbds_pkg::FBDS_RELEASE_WAIT,
            fbds_pkg::FBDS_ACTIVE: begin
                if (st_q == fbds_pkg::FBDS_RELEASE_WAIT && tmr_q == '0) begin
                    st_d      = fbds_pkg::FBDS_ACTIVE;
                    brk_rel_d = brake_fitted;
                end
                if (hard_off) begin
                    // No delay is possible: the stage is cut in hardware.
                    st_d      = fbds_pkg::FBDS_IDLE;
                    pwr_d     = 1'b0;
                    brk_rel_d = 1'b0;
                end else if (!hw_en_s) begin
                    brk_rel_d = 1'b0;
                    if (hw_hold != '0) begin
                        st_d   = fbds_pkg::FBDS_HW_HOLD;
                        tmr_d  = hw_hold;
                        stop_d = 1'b1;
                    end else begin
                        st_d  = fbds_pkg::FBDS_IDLE;
                        pwr_d = 1'b0;
                    end
                end else if (!sw_enable || cs_input) begin
                    if (brake_immediate_on_disable == `FBDS_BRAKE_IMM_ON) begin
                        brk_rel_d = 1'b0;
                    end
                    if (cs_mode || cs_input) begin
                        st_d   = fbds_pkg::FBDS_STOPPING;
                        stop_d = 1'b1;
                    end else begin
                        st_d      = fbds_pkg::FBDS_APPLY_WAIT;
                        brk_rel_d = 1'b0;
                        tmr_d     = brake_apply_delay;
                    end
                end
            end
            fbds_pkg::FBDS_STOPPING: begin
                stop_d = 1'b1;
                if (brake_immediate_on_disable == `FBDS_BRAKE_IMM_ON) begin
                    brk_rel_d = 1'b0;
                end
                if (hard_off || !hw_en_s) begin
                    st_d      = fbds_pkg::FBDS_IDLE;
                    pwr_d     = 1'b0;
                    brk_rel_d = 1'b0;
                    stop_d    = 1'b0;
                end else if (stop_impossible) begin
                    st_d      = fbds_pkg::FBDS_IDLE;
                    pwr_d     = 1'b0;
                    brk_rel_d = 1'b0;
                    db_d      = (disable_action_select == `FBDS_DISMODE_CS_DB);
                    stop_d    = 1'b0;
                end else if (stop_complete) begin
                    st_d      = fbds_pkg::FBDS_APPLY_WAIT;
                    brk_rel_d = 1'b0;
                    tmr_d     = brake_apply_delay;
                    stop_d    = 1'b0;
                end
            end
            fbds_pkg::FBDS_APPLY_WAIT: begin
                brk_rel_d = 1'b0;
                if (hard_off || tmr_q == '0) begin
                    st_d  = fbds_pkg::FBDS_IDLE;
                    pwr_d = 1'b0;
                end
            end
            fbds_pkg::FBDS_HW_HOLD: begin
                brk_rel_d = 1'b0;
                stop_d    = 1'b1;
                if (hard_off || tmr_q == '0) begin
                    st_d   = fbds_pkg::FBDS_IDLE;
                    pwr_d  = 1'b0;
                    stop_d = 1'b0;
                end
            end
            default: begin
                st_d  = fbds_pkg::FBDS_IDLE;
                pwr_d = 1'b0;
            end
        endcase
        if (flt_d) begin
            pwr_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q      <= fbds_pkg::FBDS_IDLE;
            tmr_q     <= '0;
            pwr_q     <= 1'b0;
            brk_rel_q <= 1'b0;
            db_q      <= 1'b0;
            stop_q    <= 1'b0;
        end else begin
            st_q      <= st_d;
            tmr_q     <= tmr_d;
            pwr_q     <= pwr_d;
            brk_rel_q <= brk_rel_d;
            db_q      <= db_d;
            stop_q    <= stop_d;
        end
    end

    assign power_stage_on     = pwr_q;
    assign brake_release      = brk_rel_q;
    assign dynamic_brake      = db_q;
    assign stop_request       = stop_q;
    assign fold_warning       = warn_q;
    assign fold_fault         = flt_q;
    assign motor_fold_limit   = mlim_q;
    assign overall_fold_limit = olim_q;
endmodule

// >>> testbench/fbds_seq_bench.sv
`timescale 1ns/1ps
module fbds_seq_bench;
    localparam int HMAX = 50;
    localparam logic [5:0] P = 6'h20, B = 6'h10, D = 6'h08, S = 6'h04, W = 6'h02, F = 6'h01;
    typedef struct {logic [5:0] m; logic [5:0] e;} fbds_note_t;
    logic        core_clk = 1'b0, rst = 1'b1, f_rst = 1'b0, fitted = 1'b0, imm = 1'b0;
    logic        hw = 1'b0, sw = 1'b0, sto = 1'b0, stp = 1'b0, cant = 1'b0;
    logic [15:0] drv_lim = 16'h1000, demand = 16'h0000, warn = 16'h0000, uflt = 16'hFFFF;
    logic [19:0] rel_d, app_d, hw_d = 20'h0;
    logic [1:0]  mode = 2'h0;
    logic [3:0]  fsel = 4'h0;
    logic [7:0]  slen = 8'h08;
    logic [19:0] phold;
    logic [15:0] dmd_hi = 16'h0000;
    logic        pso, brk, db, sreq, fwarn, ffault, scomp, simp;
    logic [15:0] mlim, olim;
    wire  [5:0]  obs = {pso, brk, db, sreq, fwarn, ffault};
    int          num_errors = 0, num_checks = 0, cycles = 0;
    int          seed, hold;
    int          hwd[3] = '{20, 200, 0};
    fbds_note_t  notes[$];
    fbds_note_t  n;
    event        sample_ev;
    initial forever #5 core_clk = ~core_clk;
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
        demand = (16'($urandom) & 16'h03FF) | dmd_hi;
    endtask
    task automatic check(input logic [5:0] seen, input logic [5:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic note(input logic [5:0] m, input logic [5:0] e);
        notes.push_back('{m, e});
        -> sample_ev;
    endtask
    task automatic wait_for(input logic [5:0] m, input logic [5:0] e, input int lim);
        for (int i = 0; i < lim && (obs & m) !== e; i++) cyc(1);
        note(m, e);
    endtask
    task automatic enable_drive();
        hw = 1'b1;
        sw = 1'b1;
        wait_for(P, P, 10);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial forever begin
        @(sample_ev);
        while (notes.size() > 0) begin
            n = notes.pop_front();
            check(obs & n.m, n.e);
        end
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        seed = $urandom(32'hF631);
        rel_d = 20'h4 + 20'($urandom % 8);
        app_d = 20'h4 + 20'($urandom % 8);
        phold = 20'h4 + 20'($urandom % 4);
        cyc(5);
        rst = 1'b0;
        note(6'h3F, 6'h00);
        enable_drive();
        cyc(int'(rel_d) + 4);
        note(B, 6'h00);
        sw = 1'b0;
        wait_for(P, 6'h00, int'(app_d) + 8);
        fitted = 1'b1;
        enable_drive();
        cyc(int'(rel_d) - 1);
        note(B, 6'h00);
        wait_for(B, B, 4);
        sw = 1'b0;
        cyc(2);
        note(P | B, P);
        cyc(int'(app_d) - 2);
        note(P, P);
        wait_for(P, 6'h00, 6);
        // Mode 2, mode 3 with the stop failing, and mode 2 with the immediate brake.
        for (int m = 2; m < 5; m++) begin
            mode = (m == 3) ? 2'h3 : 2'h2;
            cant = (m == 3);
            imm = (m == 4);
            enable_drive();
            wait_for(B, B, int'(rel_d) + 4);
            sw = 1'b0;
            if (m == 4) wait_for(B, 6'h00, 3);
            wait_for(S | P, S | P, 4);
            wait_for(m == 3 ? D : B, m == 3 ? D : 6'h00, int'(slen) + 6);
            wait_for(P, 6'h00, int'(app_d) + 40);
        end
        {mode, cant, imm} = 4'h0;
        slen = 8'hC8;
        foreach (hwd[k]) begin
            hw_d = 20'(hwd[k]);
            hold = (hwd[k] > HMAX) ? HMAX : hwd[k];
            enable_drive();
            wait_for(B, B, int'(rel_d) + 4);
            hw = 1'b0;
            if (hold == 0) begin
                wait_for(P, 6'h00, 5);
            end else begin
                wait_for(B, 6'h00, 4);
                note(P | S, P | S);
                cyc(hold - 6);
                note(P, P);
                wait_for(P, 6'h00, 12);
            end
            sw = 1'b0;
        end
        slen = 8'h08;
        enable_drive();
        sto = 1'b1;
        wait_for(P, 6'h00, 5);
        cyc(5);
        note(P, 6'h00);
        sw = 1'b0;
        sto = 1'b0;
        fsel = 4'hD;
        enable_drive();
        stp = 1'b1;
        wait_for(S, S, 6);
        wait_for(P, 6'h00, int'(app_d) + 30);
        sw = 1'b0;
        stp = 1'b0;
        enable_drive();
        warn = 16'h0300;
        drv_lim = 16'h0280;
        wait_for(W, W, 250);
        note(F | P, P);
        drv_lim = 16'h0100;
        wait_for(F, F, 250);
        wait_for(P, 6'h00, 3);
        uflt = 16'h0080;
        cyc(250);
        note(F, F);
        f_rst = 1'b1;
        wait_for(F, 6'h00, 250);
        f_rst = 1'b0;
        warn = 16'h0000;
        cyc(250);
        note(W, 6'h00);
        // Demand above the continuous rating: hold at peak first, then decay past the warning.
        drv_lim = 16'h1000;
        warn = 16'h0800;
        dmd_hi = 16'h0800;
        cyc(int'(phold) * 100);
        note(W, 6'h00);
        wait_for(W, W, 4000);
        dmd_hi = 16'h0000;
        wait_for(W, 6'h00, 250);
        cyc(1);
        tally_and_finish();
    end
    fbds_seq #(.HWEN_MAX_CYC(HMAX)) fbds_seq_i (
        .core_clk(core_clk), .rst(rst), .drive_fold_limit(drv_lim), .current_demand(demand),
        .motor_peak_current(16'h1000), .motor_cont_current(16'h0400),
        .motor_peak_hold_time(phold), .motor_fold_time_constant(4'h4),
        .motor_fold_recovery_time(4'h4), .warn_threshold(warn),
        .default_fault_threshold(16'h0200), .user_fault_threshold(uflt), .fault_reset(f_rst),
        .brake_fitted(fitted), .brake_release_delay(rel_d), .brake_apply_delay(app_d),
        .brake_immediate_on_disable(imm), .hw_enable_disable_delay(hw_d),
        .disable_action_select(mode), .input_function_select(fsel), .hw_enable_pin(hw),
        .sw_enable(sw), .sto_active_pin(sto), .stop_input_pin(stp), .stop_complete(scomp),
        .stop_impossible(simp), .power_stage_on(pso), .brake_release(brk),
        .dynamic_brake(db), .stop_request(sreq), .fold_warning(fwarn), .fold_fault(ffault),
        .motor_fold_limit(mlim), .overall_fold_limit(olim));
    fbds_stop_model fbds_stop_model_i (
        .core_clk(core_clk), .rst(rst), .stop_request(sreq), .cant_stop(cant),
        .stop_len(slen), .stop_complete(scomp), .stop_impossible(simp));
endmodule
bind fbds_seq fbds_seq_properties #(.CUR_W(CUR_W), .TIME_W(TIME_W),
    .HWEN_MAX_CYC(HWEN_MAX_CYC)) fbds_seq_properties_i (
    .core_clk, .rst, .warn_threshold, .default_fault_threshold, .user_fault_threshold,
    .fault_reset, .brake_fitted, .hw_enable_disable_delay, .hw_enable_pin, .sto_active_pin,
    .power_stage_on, .brake_release, .fold_warning, .fold_fault, .motor_fold_limit,
    .overall_fold_limit);

// >>> testbench/fbds_seq_properties.sv
`timescale 1ns/1ps
module fbds_seq_properties #(
    parameter int CUR_W        = 16,
    parameter int TIME_W       = 20,
    parameter int HWEN_MAX_CYC = 50
) (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic [CUR_W-1:0]  warn_threshold,
    input wire logic [CUR_W-1:0]  default_fault_threshold,
    input wire logic [CUR_W-1:0]  user_fault_threshold,
    input wire logic              fault_reset,
    input wire logic              brake_fitted,
    input wire logic [TIME_W-1:0] hw_enable_disable_delay,
    input wire logic              hw_enable_pin,
    input wire logic              sto_active_pin,
    input wire logic              power_stage_on,
    input wire logic              brake_release,
    input wire logic              fold_warning,
    input wire logic              fold_fault,
    input wire logic [CUR_W-1:0]  motor_fold_limit,
    input wire logic [CUR_W-1:0]  overall_fold_limit
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [CUR_W-1:0] eff_fault;
    logic [31:0]      hold_q;
    logic [31:0]      hold_d;
    assign eff_fault = (user_fault_threshold < default_fault_threshold) ?
                       user_fault_threshold : default_fault_threshold;
    // Counts how long power outlives a dropped hardware enable.
    always_comb begin
        hold_d = (power_stage_on && !hw_enable_pin) ? hold_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge core_clk) begin
        hold_q <= rst ? 32'h0 : hold_d;
    end
    sequence limits_settled;
        ($stable(motor_fold_limit) && $stable(overall_fold_limit))[*3];
    endsequence
    sequence below_fault;
        (overall_fold_limit < eff_fault)[*3];
    endsequence
    a_overall_is_min: assert property (
        limits_settled |-> overall_fold_limit <= motor_fold_limit)
        else $error("overall limit above motor limit");
    a_fault_raised: assert property (below_fault |-> fold_fault)
        else $error("fault missing below threshold");
    a_fault_latched: assert property (fold_fault && !fault_reset |=> fold_fault)
        else $error("fault dropped without reset");
    a_fault_no_power: assert property (fold_fault [*2] |-> !power_stage_on)
        else $error("power on during fault");
    a_warn_raised: assert property (
        (warn_threshold != '0 && overall_fold_limit < warn_threshold)[*3] |-> fold_warning)
        else $error("warning missing below level");
    a_warn_disabled: assert property ((warn_threshold == '0)[*2] |-> !fold_warning)
        else $error("warning with zero level");
    a_release_after_on: assert property ($rose(brake_release) |-> $past(power_stage_on))
        else $error("brake released without power");
    a_no_brake_fitted: assert property (!brake_fitted [*2] |-> !brake_release)
        else $error("release without brake fitted");
    a_sto_cuts_power: assert property (sto_active_pin |-> ##[1:4] !power_stage_on)
        else $error("power held under safe torque off");
    a_hw_zero_delay: assert property (
        (hw_enable_disable_delay == '0 && !hw_enable_pin)[*5] |-> !power_stage_on)
        else $error("power held with zero enable delay");
    a_hw_hold_cap: assert property (hold_q <= 32'(HWEN_MAX_CYC) + 32'h6)
        else $error("enable hold exceeds its cap");
endmodule

// >>> testbench/fbds_stop_model.sv
`timescale 1ns/1ps
module fbds_stop_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       stop_request,
    input  wire logic       cant_stop,
    input  wire logic [7:0] stop_len,
    output logic            stop_complete,
    output logic            stop_impossible
);
    logic [7:0] cnt_q;
    always_ff @(posedge core_clk) begin
        if (rst || !stop_request) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'hFF) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    // The ramp reports one outcome after stop_len cycles, success or not.
    assign stop_complete   = stop_request && !cant_stop && (cnt_q == stop_len);
    assign stop_impossible = stop_request && cant_stop && (cnt_q == stop_len);
endmodule
